//--- hdl/eeprom_two_wire_slave.sv
// Purpose: Two-wire slave front end of a byte EEPROM with a serial number area.
// Assumes: link_clk oversamples SCL/SDA; clk times the programming cycle.
// Notes:   SDA is open drain; sda_oe high pulls the line low.
`timescale 1ns/1ps
module eeprom_two_wire_slave import eeprom_pkg::*; #(
    parameter int ADDR_W = MAX_AW,
    parameter int PROG_CYCLES = PROG_CYCLES_DFLT,
    parameter logic [127:0] SERIAL_NUMBER = SERIAL_DFLT
) (
    // System clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Two-wire link
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps and protection
    input wire logic strap_select_bit2,
    input wire logic strap_select_bit1,
    input wire logic strap_select_bit0,
    input wire logic write_protect,
    // Status
    output logic programming
);

    // ****************************************
    // Declarations
    // ****************************************
    // 7 for the small array, 8 for the large one
    localparam logic [7:0] ADDR_MASK = 8'hff >> (MAX_AW - ADDR_W);

    link_type l_r;
    link_type l_nxt;
    clk_type c_r;
    clk_type c_nxt;
    logic lrst_s1;
    logic lrst_n;
    logic [7:0] mem_rdata;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic dev_match;
    logic done_evt;
    logic [7:0] rd_byte;
    logic [7:0] rd_ptr;

    // ****************************************
    // Link reset
    // ****************************************
    // Reset reaches the link side through two flops
    always_ff @(posedge link_clk) begin
        lrst_s1 <= resetn;
        lrst_n <= lrst_s1;
    end

    // ****************************************
    // Glitch filter
    // ****************************************
    // A level must hold for the suppression time before it is believed
    function automatic logic [FILT_W:0] glitch(input logic s, input logic f,
                                               input logic [FILT_W-1:0] c);
        logic [FILT_W:0] r;
        r = {f, {FILT_W{1'b0}}};
        if (s != f) begin
            if (c == FILT_W'(FILT_CYCLES - 1)) begin
                r = {s, {FILT_W{1'b0}}};
            end else begin
                r = {f, c + 1'b1};
            end
        end
        return r;
    endfunction

    // ****************************************
    // Array
    // ****************************************
    eeprom_array #(
        .AW(ADDR_W)
    ) u_array (
        .clk(link_clk),
        .wr(l_r.wr),
        .raddr(l_r.ptr[ADDR_W-1:0]),
        .rdata_r(mem_rdata)
    );

    // ****************************************
    // Link decode
    // ****************************************
    assign scl_rise = l_r.scl_f & ~l_r.scl_p;
    assign scl_fall = ~l_r.scl_f & l_r.scl_p;
    assign start_det = l_r.scl_f & l_r.scl_p & ~l_r.sda_f & l_r.sda_p;
    assign stop_det = l_r.scl_f & l_r.scl_p & l_r.sda_f & ~l_r.sda_p;
    // Array or serial area, straps compared
    assign dev_match = ((l_r.sh[7:4] == AREA_ARRAY) || (l_r.sh[7:4] == AREA_SERIAL))
                       && (l_r.sh[3:1] == l_r.strap_s2);
    assign done_evt = l_r.done_s2 != l_r.done_seen;
    // Serial byte 0 is the most significant
    assign rd_byte = l_r.area_sn ? SERIAL_NUMBER[{~l_r.ptr[3:0], 3'b111} -: 8] : mem_rdata;
    // Reads roll over the whole area; shared pointer
    assign rd_ptr = l_r.area_sn ? {l_r.ptr[7:4], l_r.ptr[3:0] + 4'h1}
                                : ((l_r.ptr + 8'h01) & ADDR_MASK);

    // ****************************************
    // Link state
    // ****************************************
    always_comb begin
        l_nxt = l_r;
        l_nxt.scl_s1 = scl_in;
        l_nxt.scl_s2 = l_r.scl_s1;
        l_nxt.sda_s1 = sda_in;
        l_nxt.sda_s2 = l_r.sda_s1;
        l_nxt.strap_s1 = {strap_select_bit2, strap_select_bit1, strap_select_bit0};
        l_nxt.strap_s2 = l_r.strap_s1;
        l_nxt.wp_s1 = write_protect;
        l_nxt.wp_s2 = l_r.wp_s1;
        l_nxt.done_s1 = c_r.done_tgl;
        l_nxt.done_s2 = l_r.done_s1;
        {l_nxt.scl_f, l_nxt.scl_cnt} = glitch(l_r.scl_s2, l_r.scl_f, l_r.scl_cnt);
        {l_nxt.sda_f, l_nxt.sda_cnt} = glitch(l_r.sda_s2, l_r.sda_f, l_r.sda_cnt);
        l_nxt.scl_p = l_r.scl_f;
        l_nxt.sda_p = l_r.sda_f;
        l_nxt.wr.we = 1'b0;
        if (l_r.st == L_PROG) begin
            // Bus ignored; page drains into the array meanwhile
            l_nxt.oe = 1'b0;
            l_nxt.wr.we = l_r.mask[l_r.prog_idx];
            l_nxt.wr.addr = {l_r.ptr[7:PAGE_AW], l_r.prog_idx};
            l_nxt.wr.data = l_r.page[l_r.prog_idx];
            l_nxt.mask[l_r.prog_idx] = 1'b0;
            l_nxt.prog_idx = l_r.prog_idx + 3'h1;
            // Done waits until every buffered byte has been written
            if (done_evt && (l_r.mask == 8'h00)) begin
                l_nxt.done_seen = l_r.done_s2;
                l_nxt.st = L_IDLE;
            end
        end else if (start_det) begin
            // Any Start outside programming, even mid-byte, restarts addressing
            l_nxt.st = L_DEV;
            l_nxt.bits = 4'h0;
            l_nxt.oe = 1'b0;
            l_nxt.got_data = 1'b0;
            l_nxt.mask = 8'h00;
        end else if (stop_det) begin
            l_nxt.oe = 1'b0;
            l_nxt.bits = 4'h0;
            if ((l_r.st == L_DATA) && l_r.got_data && !l_r.wp_s2) begin
                l_nxt.st = L_PROG;
                l_nxt.req_tgl = ~l_r.req_tgl;
                l_nxt.prog_idx = 3'h0;
            end else begin
                l_nxt.st = L_IDLE;
                l_nxt.mask = 8'h00;
            end
        end else if (scl_rise && (l_r.st != L_IDLE)) begin
            if (l_r.bits < BIT_ACK) begin
                l_nxt.sh = {l_r.sh[6:0], l_r.sda_f};
                if (l_r.st == L_READ) begin
                    l_nxt.tx = {l_r.tx[6:0], 1'b1};
                end
            end else begin
                l_nxt.acked = ~l_r.sda_f;
            end
            l_nxt.bits = l_r.bits + 4'h1;
        end else if (scl_fall && (l_r.st != L_IDLE)) begin
            if (l_r.bits == BIT_ACK) begin
                unique case (l_r.st)
                    L_DEV: begin
                        if (dev_match) begin
                            l_nxt.oe = 1'b1;
                            l_nxt.area_sn = l_r.sh[4];
                            l_nxt.acked = 1'b1;
                            l_nxt.st = l_r.sh[0] ? L_READ : L_WORD;
                        end else begin
                            l_nxt.st = L_IDLE;
                        end
                    end
                    L_WORD: begin
                        l_nxt.oe = 1'b1;
                        l_nxt.ptr = l_r.area_sn ? l_r.sh : (l_r.sh & ADDR_MASK);
                        l_nxt.st = L_DATA;
                    end
                    L_DATA: begin
                        // Serial area takes pointer loads only, never data
                        if (!l_r.area_sn) begin
                            l_nxt.oe = 1'b1;
                            l_nxt.page[l_r.ptr[PAGE_AW-1:0]] = l_r.sh;
                            l_nxt.mask[l_r.ptr[PAGE_AW-1:0]] = 1'b1;
                            l_nxt.ptr = {l_r.ptr[7:PAGE_AW], l_r.ptr[PAGE_AW-1:0] + 3'h1};
                            l_nxt.got_data = 1'b1;
                        end
                    end
                    L_READ: begin
                        l_nxt.oe = 1'b0;
                    end
                    L_IDLE, L_PROG: begin
                    end
                endcase
            end else if (l_r.bits == BIT_END) begin
                l_nxt.bits = 4'h0;
                l_nxt.oe = 1'b0;
                if (l_r.st == L_READ) begin
                    if (l_r.acked) begin
                        l_nxt.tx = rd_byte;
                        l_nxt.oe = ~rd_byte[7];
                        l_nxt.ptr = rd_ptr;
                    end else begin
                        l_nxt.st = L_IDLE;
                    end
                end
            end else if (l_r.st == L_READ) begin
                l_nxt.oe = ~l_r.tx[7];
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            l_r <= '0;
            l_r.st <= L_IDLE;
            // Idle bus level, so no false edge follows reset
            l_r.scl_s1 <= 1'b1;
            l_r.scl_s2 <= 1'b1;
            l_r.sda_s1 <= 1'b1;
            l_r.sda_s2 <= 1'b1;
            l_r.scl_f <= 1'b1;
            l_r.sda_f <= 1'b1;
            l_r.scl_p <= 1'b1;
            l_r.sda_p <= 1'b1;
        end else begin
            l_r <= l_nxt;
        end
    end

    // ****************************************
    // Programming timer
    // ****************************************
    // Counted on clk since the link clock may stop between frames
    always_comb begin
        c_nxt = c_r;
        c_nxt.req_s1 = l_r.req_tgl;
        c_nxt.req_s2 = c_r.req_s1;
        if (c_r.busy) begin
            if (c_r.cnt == 32'(PROG_CYCLES - 1)) begin
                c_nxt.busy = 1'b0;
                c_nxt.done_tgl = ~c_r.done_tgl;
            end else begin
                c_nxt.cnt = c_r.cnt + 32'h1;
            end
        end else if (c_r.req_s2 != c_r.req_seen) begin
            c_nxt.req_seen = c_r.req_s2;
            c_nxt.busy = 1'b1;
            c_nxt.cnt = 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            c_r <= '0;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = l_r.oe;
    assign programming = c_r.busy;

    // ****************************************
    // Checks
    // ****************************************
    a_quiet_busy: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (l_r.st == L_PROG) |-> !l_r.oe)
        else $error("device drove SDA during programming");

    a_poll_ignored: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (l_r.st == L_PROG) && start_det && !done_evt |=> (l_r.st == L_PROG))
        else $error("start accepted while programming");

    a_prog_needs_byte: assert property (@(posedge link_clk) disable iff (!lrst_n)
        $rose(l_r.st == L_PROG) |-> $past(l_r.got_data) && !$past(l_r.wp_s2))
        else $error("programming began without data or while protected");

    a_start_to_addr: assert property (@(posedge link_clk) disable iff (!lrst_n)
        start_det && (l_r.st != L_PROG) |=> (l_r.st == L_DEV) && (l_r.bits == 4'h0))
        else $error("start did not restart addressing");

    a_stop_standby: assert property (@(posedge link_clk) disable iff (!lrst_n)
        stop_det && (l_r.st != L_PROG) && (l_r.st != L_DATA) |=> (l_r.st == L_IDLE))
        else $error("stop did not return to standby");

    a_addr_ack: assert property (@(posedge link_clk) disable iff (!lrst_n)
        scl_fall && (l_r.bits == BIT_ACK) && (l_r.st == L_DEV) && dev_match
        && !start_det && !stop_det |=> l_r.oe ##1 l_r.oe)
        else $error("matching address not acknowledged");

    a_addr_nack: assert property (@(posedge link_clk) disable iff (!lrst_n)
        scl_fall && (l_r.bits == BIT_ACK) && (l_r.st == L_DEV) && !dev_match
        && !start_det && !stop_det |=> (l_r.st == L_IDLE) && !l_r.oe)
        else $error("mismatched address not refused");

    a_dir_select: assert property (@(posedge link_clk) disable iff (!lrst_n)
        scl_fall && (l_r.bits == BIT_ACK) && (l_r.st == L_DEV) && dev_match
        && !start_det && !stop_det |=> (l_r.st == ($past(l_r.sh[0]) ? L_READ : L_WORD)))
        else $error("direction bit not honoured");

    a_page_wrap: assert property (@(posedge link_clk) disable iff (!lrst_n)
        scl_fall && (l_r.bits == BIT_ACK) && (l_r.st == L_DATA) && !l_r.area_sn
        && !start_det && !stop_det
        |=> (l_r.ptr[7:PAGE_AW] == $past(l_r.ptr[7:PAGE_AW]))
        && (l_r.ptr[PAGE_AW-1:0] == $past(l_r.ptr[PAGE_AW-1:0]) + 3'h1))
        else $error("page address did not wrap in page");

    a_serial_locked: assert property (@(posedge link_clk) disable iff (!lrst_n)
        scl_fall && (l_r.bits == BIT_ACK) && (l_r.st == L_DATA) && l_r.area_sn
        && !start_det && !stop_det |=> !l_r.oe && (l_r.mask == $past(l_r.mask)))
        else $error("serial area accepted data");

    a_prog_length: assert property (@(posedge clk) disable iff (!resetn)
        $fell(c_r.busy) |-> ($past(c_r.cnt) == 32'(PROG_CYCLES - 1)))
        else $error("programming cycle length wrong");

endmodule

//--- inc/eeprom_pkg.sv
// Purpose: Shared constants and types for the two-wire EEPROM slave front end.
// Assumes: System clock at 20 MHz, link sampling clock with a 30 ns period.
// Notes:   All state records are packed structs registered whole.
package eeprom_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int MAX_AW = 8;
    localparam int PAGE_AW = 3;
    localparam logic [3:0] AREA_ARRAY = 4'ha;
    localparam logic [3:0] AREA_SERIAL = 4'hb;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 20;
    localparam int PROG_TIME_US = 5000;
    // Longest time, so round down
    localparam int PROG_CYCLES_DFLT = PROG_TIME_US * CLK_MHZ;
    localparam int LINK_PERIOD_NS = 30;
    localparam int NOISE_NS = 50;
    // Least time, so round up
    localparam int FILT_CYCLES = (NOISE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int FILT_W = 2;

    // Arbitrary value, stands in for a factory number
    localparam logic [127:0] SERIAL_DFLT = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [5:0] {
        L_IDLE = 6'b000001,
        L_DEV  = 6'b000010,
        L_WORD = 6'b000100,
        L_DATA = 6'b001000,
        L_READ = 6'b010000,
        L_PROG = 6'b100000
    } link_state_type;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } mem_wr_type;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic [2:0] strap_s1;
        logic [2:0] strap_s2;
        logic wp_s1;
        logic wp_s2;
        logic done_s1;
        logic done_s2;
        logic done_seen;
        logic scl_f;
        logic sda_f;
        logic scl_p;
        logic sda_p;
        logic [FILT_W-1:0] scl_cnt;
        logic [FILT_W-1:0] sda_cnt;
        link_state_type st;
        logic [3:0] bits;
        logic [7:0] sh;
        logic [7:0] tx;
        logic oe;
        logic area_sn;
        logic acked;
        logic [7:0] ptr;
        logic [7:0][7:0] page;
        logic [7:0] mask;
        logic [2:0] prog_idx;
        logic req_tgl;
        logic got_data;
        mem_wr_type wr;
    } link_type;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic done_tgl;
        logic busy;
        logic [31:0] cnt;
    } clk_type;

endpackage

//--- hdl/eeprom_array.sv
// Purpose: Byte array behind the two-wire slave, registered read data.
// Assumes: Single clock, one write and one read port.
// Notes:   Contents survive the slave's reset; the pointer is cleared by it.
`timescale 1ns/1ps
module eeprom_array import eeprom_pkg::*; #(
    parameter int AW = 8
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire mem_wr_type wr,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata_r
);

    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (wr.we) begin
            mem[wr.addr[AW-1:0]] <= wr.data;
        end
        rdata_r <= mem[raddr];
    end

endmodule

//--- sim/bus_controller_model.sv
// Purpose: Two-wire bus controller model that drives SCL and pulls SDA.
// Assumes: The bench resolves SDA from all pulls, with a pull-up.
// Notes:   SCL stands high between frames; half sets the bus speed.
`timescale 1ns/1ps
module bus_controller_model (
    // Clock
    input wire logic clk,
    // Two-wire lines
    output logic scl,
    output logic sda_pull,
    input wire logic sda_wire
);
    int half = 6;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Hold after the fall outlasts the slave's input filter delay
    task automatic put_bit(input logic b, output logic seen);
        sda_pull <= ~b;
        tick(half);
        scl <= 1'b1;
        tick(half);
        seen = sda_wire;
        scl <= 1'b0;
        tick(4);
    endtask
    task automatic start_cond();
        sda_pull <= 1'b0;
        tick(half);
        scl <= 1'b1;
        tick(half);
        sda_pull <= 1'b1;
        tick(half);
        scl <= 1'b0;
        tick(4);
    endtask
    task automatic stop_cond();
        sda_pull <= 1'b1;
        tick(half);
        scl <= 1'b1;
        tick(half);
        sda_pull <= 1'b0;
        tick(2 * half);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv_byte(input logic ack_it, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
        put_bit(~ack_it, s);
    endtask
    // SDA released: partial bytes and bare recovery clocks
    task automatic pulses(input int n);
        logic s;
        repeat (n) put_bit(1'b1, s);
    endtask
endmodule

//--- sim/tb_eeprom_two_wire_slave.sv
// Purpose: Self-checking bench for the two-wire EEPROM slave.
// Assumes: Controller model drives SCL and shares the open-drain SDA.
// Notes:   A short programming count keeps the run brief.
`timescale 1ns/1ps
module tb_eeprom_two_wire_slave;
    import eeprom_pkg::*;
    localparam int PROG = 400;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic resetn = 1'b0;
    logic wp = 1'b0;
    logic [2:0] strap = 3'h5;
    logic scl;
    logic sda_pull;
    logic sda_out;
    logic sda_oe;
    logic programming;
    logic sda_wire;
    int fail_count = 0;
    int checks_done = 0;
    int prog_run = 0;
    int last_len = 0;

    always #25 clk = ~clk;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));
    always @(posedge clk) begin
        if (programming) begin
            prog_run <= prog_run + 1;
        end else begin
            if (prog_run != 0) last_len <= prog_run;
            prog_run <= 0;
        end
    end

    eeprom_two_wire_slave #(.PROG_CYCLES(PROG)) i_dut (
        .clk(clk), .resetn(resetn), .link_clk(link_clk), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .strap_select_bit2(strap[2]), .strap_select_bit1(strap[1]),
        .strap_select_bit0(strap[0]), .write_protect(wp), .programming(programming));
    bus_controller_model i_host (
        .clk(clk), .scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] dev(input logic [3:0] area, input logic rd);
        return {area, strap, rd};
    endfunction
    task automatic probe(input logic [7:0] addr, output logic ack);
        i_host.start_cond();
        i_host.send_byte(addr, ack);
        i_host.stop_cond();
    endtask
    task automatic write_page(input logic [7:0] word, input logic [7:0] base, input int n);
        logic a;
        i_host.start_cond();
        i_host.send_byte(dev(AREA_ARRAY, 1'b0), a);
        check_bit("addr ack", 1'b1, a);
        i_host.send_byte(word, a);
        check_bit("word ack", 1'b1, a);
        for (int i = 0; i < n; i++) begin
            i_host.send_byte(base + 8'(i), a);
            check_bit("data ack", 1'b1, a);
        end
        i_host.stop_cond();
    endtask
    // First expected byte sits in the low bits of exp
    task automatic read_check(input logic [3:0] area, input logic dummy, input logic [7:0] word,
                              input int n, input logic [63:0] exp);
        logic a;
        logic [7:0] b;
        if (dummy) begin
            i_host.start_cond();
            i_host.send_byte(dev(area, 1'b0), a);
            i_host.send_byte(word, a);
        end
        i_host.start_cond();
        i_host.send_byte(dev(area, 1'b1), a);
        check_bit("read addr ack", 1'b1, a);
        for (int i = 0; i < n; i++) begin
            i_host.recv_byte(i + 1 < n, b);
            check_byte("read data", exp[8*i +: 8], b);
        end
        i_host.stop_cond();
    endtask
    task automatic wait_prog(input logic expect_run);
        int n;
        logic a;
        n = 0;
        while (!programming && n < 20) begin
            @(posedge clk);
            n++;
        end
        check_bit("programming started", expect_run, programming);
        if (programming === 1'b1) begin
            probe(dev(AREA_ARRAY, 1'b0), a);
            check_bit("poll during write", 1'b0, a);
            n = 0;
            while (programming && n < PROG + 50) begin
                @(posedge clk);
                n++;
            end
            repeat (10) @(posedge clk);
            check_bit("cycle length", 1'b1, last_len == PROG);
        end
        probe(dev(AREA_ARRAY, 1'b0), a);
        check_bit("poll after write", 1'b1, a);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_byte_write();
        write_page(8'h20, 8'h5a, 1);
        wait_prog(1'b1);
        read_check(AREA_ARRAY, 1'b1, 8'h20, 1, 64'h5a);
        $display("test byte_write done");
    endtask
    task automatic t_page_wrap();
        write_page(8'h15, 8'h30, 9);
        wait_prog(1'b1);
        read_check(AREA_ARRAY, 1'b0, 8'h00, 2, 64'h3231);
        read_check(AREA_ARRAY, 1'b1, 8'h10, 8, 64'h3231383736353433);
        $display("test page_wrap done");
    endtask
    task automatic t_refuse();
        logic a;
        logic [7:0] bad [4];
        bad = '{{4'hc, strap, 1'b0}, {AREA_ARRAY, strap ^ 3'h1, 1'b0},
                {AREA_ARRAY, strap ^ 3'h2, 1'b0}, {AREA_SERIAL, strap ^ 3'h4, 1'b1}};
        for (int i = 0; i < 4; i++) begin
            probe(bad[i], a);
            check_bit("refused address", 1'b0, a);
        end
        strap <= 3'h2;
        repeat (4) @(posedge clk);
        probe(dev(AREA_ARRAY, 1'b0), a);
        check_bit("new strap ack", 1'b1, a);
        $display("test refuse done");
    endtask
    task automatic t_serial();
        logic a;
        read_check(AREA_SERIAL, 1'b1, 8'h80, 2,
                   64'({SERIAL_DFLT[119:112], SERIAL_DFLT[127:120]}));
        i_host.start_cond();
        i_host.send_byte(dev(AREA_SERIAL, 1'b0), a);
        i_host.send_byte(8'h80, a);
        check_bit("serial pointer ack", 1'b1, a);
        i_host.send_byte(8'h00, a);
        check_bit("serial data ack", 1'b0, a);
        i_host.stop_cond();
        wait_prog(1'b0);
        read_check(AREA_SERIAL, 1'b1, 8'h80, 1, 64'(SERIAL_DFLT[127:120]));
        $display("test serial done");
    endtask
    task automatic t_protect();
        wp <= 1'b1;
        repeat (4) @(posedge clk);
        write_page(8'h20, 8'ha5, 1);
        wait_prog(1'b0);
        read_check(AREA_ARRAY, 1'b1, 8'h20, 1, 64'h5a);
        wp <= 1'b0;
        $display("test protect done");
    endtask
    task automatic t_abort();
        logic a;
        i_host.start_cond();
        i_host.send_byte(dev(AREA_ARRAY, 1'b0), a);
        i_host.send_byte(8'h20, a);
        i_host.pulses(4);
        i_host.start_cond();
        i_host.stop_cond();
        wait_prog(1'b0);
        read_check(AREA_ARRAY, 1'b1, 8'h20, 1, 64'h5a);
        $display("test abort done");
    endtask
    // Slow bus: the controller stretches every half bit
    task automatic t_recover();
        logic a;
        i_host.half = 12;
        i_host.start_cond();
        i_host.send_byte(dev(AREA_ARRAY, 1'b0), a);
        i_host.pulses(3);
        i_host.start_cond();
        i_host.pulses(9);
        i_host.start_cond();
        i_host.stop_cond();
        wait_prog(1'b0);
        i_host.half = 6;
        $display("test recover done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (10) @(posedge clk);
        t_byte_write();
        t_page_wrap();
        t_refuse();
        t_serial();
        t_protect();
        t_abort();
        t_recover();
        complete_run();
    end
    initial begin
        #3000000;
        fail_count++;
        complete_run();
    end
endmodule
